// >>> rtl/vme_readout_interrupter.sv
// Register access, output-buffer readout, chained readout and interrupter
// What this block does
// - 16-bit interrupt acknowledge returns the status/ID in the low byte.
// - Status/ID is the low byte of the interrupt vector register.
// - Request drives exactly one of seven IRQ lines, chosen by level.
// - Interrupt raised when stored words equal the almost-full threshold.
// - Level zero disables interrupts; zero is the reset level.
// - Request dropped when stored words fall below threshold, or on clear unless stored words equal it.
// - Data-ready status reads one while a complete event is stored.
// - Early single read gives fillers, or bus error if enabled.
// - Plain block read streams words, then pads the rest with fillers.
// - Block read with bus error enabled ends with bus error, no fillers.
// - Event-aligned mode runs only with a nonzero event count register.
// - Aligned, no bus error, few events: send all, then fillers.
// - Aligned, no bus error, many events: count events, then fillers.
// - Aligned with bus error, few events: send all, then bus error.
// - Aligned with bus error, many events: send count, then bus error.
// - Token holder sends its first event, then passes the token unless it is the last module.
// - Empty non-last or inactive module passes the token without data; an empty last module ends with bus error.
// - Chained reads use bus error; last module ends with bus error.
// - 64-bit chained read adds one filler after an odd word count.
// - Chain role in low two bits: 2 first, 3 middle, 0 inactive.
// - Chain access matches A31..24, needs A23..16 zero, A15..0 offset.
module vme_readout_interrupter
    import vme_tdc_pkg::*;
(
    input wire logic clk_sys, // System clock, 40 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic req, // One bus beat requested, pulse
    input wire logic req_write, // Beat is a write
    input wire logic req_base_hit, // Address matched the base address
    input wire logic [31:0] req_addr, // Full beat address
    input wire logic [15:0] req_wdata, // Write data
    input wire logic req_blt, // Beat belongs to a block cycle
    input wire logic req_first, // First beat of a block cycle
    input wire logic req_wide, // Block cycle is 64-bit
    input wire logic chain_cycle, // Chained or multicast cycle active
    input wire logic iack_cycle, // Interrupt acknowledge in progress
    input wire logic [2:0] iack_level, // Level being acknowledged
    input wire logic daisy_in, // Daisy chain input, active high
    input wire logic clear_in, // Front-panel clear pulse
    input wire logic src_valid, // Output buffer offers a word
    input wire logic [31:0] src_data, // Output buffer word
    input wire logic src_last, // Word is the global trailer
    output logic src_ready, // Block can take a word
    input wire logic [vme_tdc_pkg::CNT_W-1:0] word_count, // Words stored
    input wire logic [vme_tdc_pkg::CNT_W-1:0] event_count, // Events stored
    output logic ans_valid, // Beat answered, pulse
    output logic ans_berr, // Beat ended with bus error, pulse
    output logic [31:0] ans_data, // Read data of the answer
    output logic [7:1] irq_req, // Interrupt request lines, active high
    output logic daisy_out, // Daisy chain output, active high
    output logic clear_out // Clear pulse to the output buffer
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        CB_IDLE, CB_OWN, CB_PAD, CB_PASSED, CB_DONE
    } chain_state_type;

    typedef struct packed {
        logic berr_en;
        logic [2:0] irq_level;
        logic [15:0] irq_vector;
        logic [7:0] chain_addr;
        logic [1:0] chain_role;
        logic [15:0] af_thresh;
        logic [15:0] blt_evt_num;
        logic mid_event;
        logic [15:0] evt_sent;
        logic odd_word;
        chain_state_type chain_st;
        logic iack_served;
        logic ans_valid;
        logic ans_berr;
        logic [31:0] ans_data;
        logic daisy_out;
        logic clear;
    } state_type;

    state_type s;
    state_type n;
    logic pop;
    logic buf_valid;
    logic [32:0] buf_data;
    logic irq_pending;
    logic [15:0] off;
    logic [31:0] stat;
    logic chain_hit;
    logic token_here;

    function automatic logic addr_in_chain(input logic [31:0] a,
                                           input logic [7:0] ca);
        return a[31:24] == ca && a[23:16] == CHAIN_MID_ZERO;
    endfunction

    // ------------------------------------------------------------------
    // Datapath buffer between output memory and bus
    // ------------------------------------------------------------------
    word_skid_buffer #(.WIDTH(33)) u_buf (
        .clk_sys(clk_sys),
        .srst(srst),
        .flush(s.clear),
        .in_valid(src_valid),
        .in_data({src_last, src_data}),
        .in_ready(src_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(pop)
    );

    irq_requester u_irq (
        .clk_sys(clk_sys),
        .srst(srst),
        .level(s.irq_level),
        .word_count(word_count),
        .threshold(s.af_thresh),
        .clear(s.clear),
        .irq_req(irq_req),
        .pending(irq_pending)
    );

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        n = s;
        n.ans_valid = 1'b0;
        n.ans_berr = 1'b0;
        n.clear = clear_in;
        pop = 1'b0;
        off = req_addr[15:0];
        chain_hit = addr_in_chain(req_addr, s.chain_addr);
        token_here = (s.chain_role == ROLE_FIRST) || daisy_in;
        stat = '0;
        stat[STAT_DATA_READY_BIT] = (event_count != '0);
        stat[STAT_ALMOST_FULL_BIT] = (word_count >= s.af_thresh);
        stat[STAT_IRQ_PEND_BIT] = irq_pending;

        // Register writes, by base address or by multicast
        if (req && req_write && !req_blt && (req_base_hit ||
                (chain_hit && s.chain_role != ROLE_INACTIVE))) begin
            // Only the last module of a multicast answers the master
            n.ans_valid = req_base_hit || s.chain_role == ROLE_LAST;
            case (off)
                OFF_CONTROL: begin
                    n.berr_en = req_wdata[CTRL_BERR_EN_BIT];
                    n.clear = 1'b1;
                end
                OFF_IRQ_LEVEL: n.irq_level = req_wdata[2:0];
                OFF_IRQ_VECTOR: n.irq_vector = req_wdata;
                OFF_CHAIN_ADDR: begin
                    n.chain_addr = req_wdata[7:0];
                    n.clear = 1'b1;
                end
                OFF_CHAIN_CTRL: begin
                    n.chain_role = req_wdata[1:0];
                    n.clear = 1'b1;
                end
                OFF_SW_CLEAR: n.clear = 1'b1;
                OFF_AF_THRESH: begin
                    n.af_thresh = req_wdata;
                    n.clear = 1'b1;
                end
                OFF_BLT_EVT_NUM: n.blt_evt_num = req_wdata;
                default: n.ans_berr = req_base_hit;
            endcase
            n.ans_valid = n.ans_valid && !n.ans_berr;
        end else if (req && !req_write && req_base_hit && off > OFF_BUF_LAST)
        begin
            n.ans_valid = 1'b1;
            case (off)
                OFF_CONTROL: n.ans_data = 32'(s.berr_en);
                OFF_STATUS: n.ans_data = stat;
                OFF_IRQ_LEVEL: n.ans_data = 32'(s.irq_level);
                OFF_IRQ_VECTOR: n.ans_data = 32'(s.irq_vector);
                OFF_CHAIN_ADDR: n.ans_data = 32'(s.chain_addr);
                OFF_CHAIN_CTRL: n.ans_data = 32'(s.chain_role);
                OFF_EVT_STORED: n.ans_data = 32'(event_count);
                OFF_AF_THRESH: n.ans_data = 32'(s.af_thresh);
                OFF_BLT_EVT_NUM: n.ans_data = 32'(s.blt_evt_num);
                default: begin
                    n.ans_valid = 1'b0;
                    n.ans_berr = 1'b1;
                end
            endcase
        end else if (req && !req_write && req_base_hit) begin
            // Output buffer read by base address
            if (req_first) begin
                n.evt_sent = '0;
            end
            if (req_blt && s.blt_evt_num != '0 &&
                    n.evt_sent >= s.blt_evt_num) begin
                // Event quota of this cycle is used up
                n.ans_berr = s.berr_en;
                n.ans_valid = !s.berr_en;
                n.ans_data = FILLER_WORD;
            end else if (buf_valid && (req_blt || s.mid_event ||
                    event_count != '0)) begin
                pop = 1'b1;
                n.ans_valid = 1'b1;
                n.ans_data = buf_data[31:0];
                n.mid_event = !buf_data[32];
                if (buf_data[32] && req_blt) begin
                    n.evt_sent = 16'(n.evt_sent + 16'h0001);
                end
            end else if (s.berr_en) begin
                n.ans_berr = 1'b1;
            end else begin
                n.ans_valid = 1'b1;
                n.ans_data = FILLER_WORD;
            end
        end

        // Chained block readout, token carried on the daisy chain
        case (s.chain_st)
            CB_IDLE: begin
                n.odd_word = 1'b0;
                if (chain_cycle && (token_here ||
                        (daisy_in && s.chain_role == ROLE_INACTIVE))) begin
                    if (s.chain_role == ROLE_INACTIVE) begin
                        n.chain_st = CB_PASSED;
                    end else if (event_count == '0 && !s.mid_event) begin
                        n.chain_st = (s.chain_role == ROLE_LAST) ?
                                     CB_DONE : CB_PASSED;
                    end else begin
                        n.chain_st = CB_OWN;
                    end
                end
            end
            CB_OWN: begin
                if (req && !req_write && req_blt && chain_hit) begin
                    if (buf_valid) begin
                        pop = 1'b1;
                        n.ans_valid = 1'b1;
                        n.ans_data = buf_data[31:0];
                        n.mid_event = !buf_data[32];
                        n.odd_word = !s.odd_word;
                        if (buf_data[32]) begin
                            if (req_wide && !s.odd_word) begin
                                n.chain_st = CB_PAD;
                            end else begin
                                n.chain_st = (s.chain_role == ROLE_LAST) ?
                                             CB_DONE : CB_PASSED;
                            end
                        end
                    end else begin
                        // Event not yet fully in the buffer: forced bus error
                        n.ans_berr = 1'b1;
                    end
                end
            end
            CB_PAD: begin
                if (req && !req_write && req_blt && chain_hit) begin
                    n.ans_valid = 1'b1;
                    n.ans_data = FILLER_WORD;
                    n.chain_st = (s.chain_role == ROLE_LAST) ?
                                 CB_DONE : CB_PASSED;
                end
            end
            CB_DONE: begin
                if (req && !req_write && req_blt && chain_hit) begin
                    n.ans_berr = 1'b1;
                end
            end
            CB_PASSED: ;
            default: n.chain_st = CB_IDLE;
        endcase
        if (!chain_cycle) begin
            n.chain_st = CB_IDLE;
        end

        // Interrupt acknowledge, served or passed down the chain
        if (!iack_cycle) begin
            n.iack_served = 1'b0;
        end else if (daisy_in && !s.iack_served) begin
            if (irq_pending && iack_level == s.irq_level) begin
                n.iack_served = 1'b1;
                n.ans_valid = 1'b1;
                n.ans_berr = 1'b0;
                n.ans_data = 32'(s.irq_vector[IRQ_ID_W-1:0]);
            end
        end
        n.daisy_out = (n.chain_st == CB_PASSED) ||
                      (iack_cycle && daisy_in && !n.iack_served &&
                       !s.iack_served);

        // A clear drops any event half read out of the buffer
        if (n.clear) begin
            n.mid_event = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
            s.berr_en <= RST_BERR_EN;
            s.irq_level <= RST_IRQ_LEVEL;
            s.irq_vector <= RST_IRQ_VECTOR;
            s.chain_addr <= RST_CHAIN_ADDR;
            s.chain_role <= RST_CHAIN_ROLE;
            s.af_thresh <= RST_AF_THRESH;
            s.blt_evt_num <= RST_BLT_EVT_NUM;
            s.chain_st <= CB_IDLE;
        end else begin
            s <= n;
        end
    end

    assign ans_valid = s.ans_valid;
    assign ans_berr = s.ans_berr;
    assign ans_data = s.ans_data;
    assign daisy_out = s.daisy_out;
    assign clear_out = s.clear;
endmodule

// >>> shared/vme_tdc_pkg.sv
// Register map, field layout and reset values of the readout block
package vme_tdc_pkg;
    // ------------------------------------------------------------------
    // Register offsets within the module window
    // ------------------------------------------------------------------
    localparam logic [15:0] OFF_BUF_LAST = 16'h0ffc;
    localparam logic [15:0] OFF_CONTROL = 16'h1000;
    localparam logic [15:0] OFF_STATUS = 16'h1002;
    localparam logic [15:0] OFF_IRQ_LEVEL = 16'h100a;
    localparam logic [15:0] OFF_IRQ_VECTOR = 16'h100c;
    localparam logic [15:0] OFF_CHAIN_ADDR = 16'h1010;
    localparam logic [15:0] OFF_CHAIN_CTRL = 16'h1012;
    localparam logic [15:0] OFF_SW_CLEAR = 16'h1016;
    localparam logic [15:0] OFF_EVT_STORED = 16'h1020;
    localparam logic [15:0] OFF_AF_THRESH = 16'h1022;
    localparam logic [15:0] OFF_BLT_EVT_NUM = 16'h1024;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int CTRL_BERR_EN_BIT = 0;
    localparam int STAT_DATA_READY_BIT = 0;
    localparam int STAT_ALMOST_FULL_BIT = 1;
    localparam int STAT_IRQ_PEND_BIT = 2;
    localparam int IRQ_ID_W = 8;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------------
    // Chain roles: 0 inactive, 1 last, 2 first, 3 middle
    // ------------------------------------------------------------------
    localparam logic [1:0] ROLE_INACTIVE = 2'h0;
    localparam logic [1:0] ROLE_LAST = 2'h1;
    localparam logic [1:0] ROLE_FIRST = 2'h2;
    localparam logic [1:0] ROLE_MIDDLE = 2'h3;

    // ------------------------------------------------------------------
    // Reset values and fixed words
    // ------------------------------------------------------------------
    localparam logic RST_BERR_EN = 1'b0;
    localparam logic [2:0] RST_IRQ_LEVEL = 3'h0;
    localparam logic [15:0] RST_IRQ_VECTOR = 16'h0000;
    localparam logic [7:0] RST_CHAIN_ADDR = 8'haa;
    localparam logic [1:0] RST_CHAIN_ROLE = ROLE_INACTIVE;
    localparam logic [15:0] RST_AF_THRESH = 16'h0040;
    localparam logic [15:0] RST_BLT_EVT_NUM = 16'h0000;
    localparam logic [7:0] CHAIN_MID_ZERO = 8'h00;
    localparam logic [31:0] FILLER_WORD = 32'h0600_0000;
endpackage

// >>> rtl/word_skid_buffer.sv
// Two-entry buffer with valid and ready on both sides
module word_skid_buffer #(
    parameter int WIDTH = 33
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic flush, // Drop all held words
    input wire logic in_valid, // Source offers a word
    input wire logic [WIDTH-1:0] in_data, // Word from source
    output logic in_ready, // Buffer can take a word
    output logic out_valid, // A word is held
    output logic [WIDTH-1:0] out_data, // Oldest held word
    input wire logic out_ready // Receiver takes the word
);
    if (WIDTH < 1) begin : g_chk
        $error("word_skid_buffer: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [1:0][WIDTH-1:0] slot;
        logic rd;
        logic [1:0] count;
        logic ready;
    } skid_type;

    skid_type s;
    skid_type n;
    logic push;
    logic pop;

    always_comb begin
        n = s;
        pop = out_ready && (s.count != 2'h0);
        push = in_valid && s.ready;
        if (push) begin
            n.slot[s.rd ^ s.count[0]] = in_data;
        end
        if (pop) begin
            n.rd = ~s.rd;
        end
        n.count = 2'(s.count + {1'b0, push} - {1'b0, pop});
        n.ready = (n.count != 2'h2);
        // Flush wins: a word offered in the same cycle is dropped too
        if (flush) begin
            n.count = 2'h0;
            n.rd = 1'b0;
            n.ready = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
            s.ready <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign in_ready = s.ready;
    assign out_valid = (s.count != 2'h0);
    assign out_data = s.slot[s.rd];
endmodule

// >>> rtl/irq_requester.sv
// Interrupt request on a programmable level, driven by buffer fill
module irq_requester
    import vme_tdc_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic [2:0] level, // Programmed level, 0 = off
    input wire logic [vme_tdc_pkg::CNT_W-1:0] word_count, // Words stored
    input wire logic [vme_tdc_pkg::CNT_W-1:0] threshold, // Fill threshold
    input wire logic clear, // Module clear pulse
    output logic [7:1] irq_req, // Request lines, active high
    output logic pending // Request is being held
);
    typedef struct packed {
        logic pending;
        logic [7:1] lines;
    } irq_type;

    irq_type s;
    irq_type n;

    function automatic logic [7:1] level_line(input logic [2:0] lvl,
                                               input logic on);
        logic [7:1] v;
        v = '0;
        if (on && lvl != 3'h0) begin
            v[lvl] = 1'b1;
        end
        return v;
    endfunction

    always_comb begin
        n = s;
        if (level != 3'h0 && word_count == threshold) begin
            n.pending = 1'b1;
        end else if (clear || level == 3'h0) begin
            n.pending = 1'b0;
        end else if (word_count < threshold) begin
            n.pending = 1'b0;
        end
        n.lines = level_line(level, n.pending);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign irq_req = s.lines;
    assign pending = s.pending;
endmodule

// >>> verification/word_source_model.sv
// Output-buffer word source that offers a short event to the block
module word_source_model (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic load, // Start a new event
    input wire logic [3:0] n, // Words in the event
    input wire logic src_ready, // Block takes a word
    output logic src_valid, // Word offered
    output logic [31:0] src_data, // Offered word
    output logic src_last // Offered word is the trailer
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] left;
    logic [3:0] idx;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            left <= 4'h0;
            idx <= 4'h0;
        end else if (load) begin
            left <= n;
            idx <= 4'h0;
        end else if (src_valid && src_ready) begin
            left <= left - 4'h1;
            idx <= idx + 4'h1;
        end
    end
    assign src_valid = left != 4'h0;
    assign src_last = left == 4'h1;
    // Idle data is inverted so a stale word never looks valid
    assign src_data = src_valid ? 32'hd000_0000 | idx : ~(32'hd000_0000 | idx);
endmodule

// >>> verification/readout_chk.sv
// Port-level assertions for the readout and interrupter block
module readout_chk
    import vme_tdc_pkg::*;
(
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic req, // Beat request
    input wire logic req_write, // Beat is a write
    input wire logic req_base_hit, // Base address hit
    input wire logic [31:0] req_addr, // Beat address
    input wire logic [15:0] req_wdata, // Write data
    input wire logic chain_cycle, // Chained cycle
    input wire logic iack_cycle, // Acknowledge cycle
    input wire logic [2:0] iack_level, // Acknowledged level
    input wire logic daisy_in, // Daisy chain in
    input wire logic clear_in, // External clear
    input wire logic [vme_tdc_pkg::CNT_W-1:0] event_count, // Events stored
    input wire logic ans_valid, // Beat answered
    input wire logic ans_berr, // Bus error
    input wire logic [31:0] ans_data, // Answer data
    input wire logic [7:1] irq_req, // Request lines
    input wire logic clear_out // Clear pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    logic lvl_on;
    logic [7:0] vec;
    logic base_wr;
    assign base_wr = req && req_write && req_base_hit;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lvl_on <= 1'b0;
            vec <= RST_IRQ_VECTOR[7:0];
        end else if (base_wr && req_addr[15:0] == OFF_IRQ_LEVEL) begin
            lvl_on <= req_wdata[2:0] != 3'h0;
        end else if (base_wr && req_addr[15:0] == OFF_IRQ_VECTOR) begin
            vec <= req_wdata[7:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    a_irq_onehot: assert property ($onehot0(irq_req))
        else $error("more than one request line high");
    a_level_zero: assert property (
        !lvl_on [*4] |-> irq_req == 7'h0) else $error("request at level 0");
    a_iack_vector: assert property (
        $rose(iack_cycle) && daisy_in && iack_level != 3'h0
        && irq_req[iack_level] |=> ans_valid && ans_data == {24'h0, vec})
        else $error("wrong acknowledge answer");
    a_status_ready: assert property (
        req && !req_write && req_base_hit && !iack_cycle && !chain_cycle
        && req_addr[15:0] == OFF_STATUS
        |=> ans_valid && ans_data[0] == ($past(event_count) != 16'h0))
        else $error("data ready bit wrong");
    a_beat_answer: assert property (
        req && req_base_hit && !iack_cycle && !chain_cycle
        |=> ans_valid || ans_berr) else $error("beat not answered");
    a_ans_excl: assert property (!(ans_valid && ans_berr))
        else $error("data and bus error together");
    a_clear_follow: assert property (clear_in |-> ##[1:2] clear_out)
        else $error("clear not forwarded");
    a_clear_drop: assert property (
        clear_out |-> ##[0:3] irq_req == 7'h0) else $error("request kept");
    c_iack: cover property ($rose(iack_cycle) ##1 ans_valid);
    c_berr: cover property (ans_berr);
    c_clear: cover property (clear_out);
endmodule

bind vme_readout_interrupter readout_chk chk_u (.clk_sys, .srst, .req,
    .req_write, .req_base_hit, .req_addr, .req_wdata, .chain_cycle,
    .iack_cycle, .iack_level, .daisy_in, .clear_in, .event_count, .ans_valid,
    .ans_berr, .ans_data, .irq_req, .clear_out);

// >>> verification/vme_readout_interrupter_test.sv
// Register, interrupt and buffer readout tests of the readout block
module vme_readout_interrupter_test;
    import vme_tdc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic req = 0, req_write = 0, req_base_hit = 1, req_blt = 0;
    logic req_first = 0, req_wide = 0, chain_cycle = 0, iack_cycle = 0;
    logic daisy_in = 0, clear_in = 0, load = 0, be;
    logic src_valid, src_last, src_ready, ans_valid, ans_berr;
    logic daisy_out, clear_out;
    logic [2:0] iack_level = 3'h0;
    logic [3:0] nwords = 4'h3;
    logic [15:0] req_wdata = 16'h0, word_count = 16'h0, event_count = 16'h0;
    logic [31:0] req_addr = 32'h0, src_data, ans_data, rd;
    logic [7:1] irq_req;
    int err_count = 0;
    int total_checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    vme_readout_interrupter dut_u (.clk_sys, .srst, .req, .req_write,
        .req_base_hit, .req_addr, .req_wdata, .req_blt, .req_first, .req_wide,
        .chain_cycle, .iack_cycle, .iack_level, .daisy_in, .clear_in,
        .src_valid, .src_data, .src_last, .src_ready, .word_count,
        .event_count, .ans_valid, .ans_berr, .ans_data, .irq_req, .daisy_out,
        .clear_out);
    word_source_model src_u (.clk_sys, .srst, .load, .n(nwords), .src_ready,
        .src_valid, .src_data, .src_last);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One beat: request taken at the next edge, answer one edge later
    task automatic acc(input logic w, input logic [15:0] off,
                       input logic [15:0] wd, input logic blt);
        @(posedge clk_sys);
        req <= 1'b1;
        req_write <= w;
        req_addr <= {16'h0, off};
        req_wdata <= wd;
        req_blt <= blt;
        @(posedge clk_sys);
        req <= 1'b0;
        @(posedge clk_sys);
        rd = ans_data;
        be = ans_berr;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
    endtask
    task automatic complete_run();
        if (err_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        tick(2000);
        err_count++;
        complete_run();
    end
    initial begin
        tick(10);
        srst <= 1'b0;
        acc(0, OFF_IRQ_VECTOR, 0, 0);
        chk(rd[15:0], RST_IRQ_VECTOR);
        acc(0, OFF_AF_THRESH, 0, 0);
        chk(rd[15:0], RST_AF_THRESH);
        acc(0, 16'h1004, 0, 0);
        chk(be, 1'b1);
        acc(1, OFF_IRQ_VECTOR, 16'h12ab, 0);
        acc(1, OFF_AF_THRESH, 16'h0002, 0);
        acc(0, OFF_IRQ_VECTOR, 0, 0);
        chk(rd[15:0], 16'h12ab);
        word_count <= 16'h0002;
        tick(4);
        chk(irq_req, 7'h00);
        acc(1, OFF_IRQ_LEVEL, 16'h0003, 0);
        tick(3);
        chk(irq_req, 7'h04);
        iack_cycle <= 1'b1;
        daisy_in <= 1'b1;
        iack_level <= 3'h3;
        tick(2);
        chk({ans_valid, ans_data}, {1'b1, 32'h0000_00ab});
        iack_cycle <= 1'b0;
        daisy_in <= 1'b0;
        word_count <= 16'h0001;
        tick(4);
        chk(irq_req, 7'h00);
        acc(1, OFF_IRQ_LEVEL, 16'h0005, 0);
        word_count <= 16'h0002;
        tick(4);
        word_count <= 16'h0003;
        chk(irq_req, 7'h10);
        clear_in <= 1'b1;
        tick(1);
        clear_in <= 1'b0;
        tick(4);
        chk(irq_req, 7'h00);
        word_count <= 16'h0000;
        acc(0, 16'h0000, 0, 0);
        chk(rd, FILLER_WORD);
        acc(1, OFF_CONTROL, 16'h0001, 0);
        acc(0, 16'h0000, 0, 0);
        chk(be, 1'b1);
        acc(0, 16'h0000, 0, 1);
        chk(be, 1'b1);
        acc(1, OFF_CONTROL, 16'h0000, 0);
        tick(3);
        load <= 1'b1;
        word_count <= 16'h0003;
        event_count <= 16'h0001;
        tick(1);
        load <= 1'b0;
        tick(4);
        acc(0, OFF_STATUS, 0, 0);
        chk(rd[0], 1'b1);
        for (int i = 0; i < 3; i++) begin
            acc(0, 16'h0000, 0, 0);
            chk(rd, 32'hd000_0000 + 32'(i));
        end
        event_count <= 16'h0000;
        word_count <= 16'h0000;
        acc(0, OFF_STATUS, 0, 0);
        chk(rd[0], 1'b0);
        acc(0, 16'h0000, 0, 1);
        chk(rd, FILLER_WORD);
        nwords <= 4'h1;
        acc(1, OFF_BLT_EVT_NUM, 16'h0001, 0);
        load <= 1'b1;
        tick(1);
        load <= 1'b0;
        tick(3);
        acc(0, 16'h0000, 0, 1);
        chk(rd, 32'hd000_0000);
        acc(0, 16'h0000, 0, 1);
        chk(rd, FILLER_WORD);
        req_first <= 1'b1;
        load <= 1'b1;
        tick(1);
        load <= 1'b0;
        tick(3);
        acc(0, 16'h0000, 0, 1);
        chk(rd, 32'hd000_0000);
        acc(1, OFF_CHAIN_CTRL, 16'h0002, 0);
        chain_cycle <= 1'b1;
        tick(3);
        chk(daisy_out, 1'b1);
        complete_run();
    end
endmodule
